/* rtl/css_defines.svh */
// constants for the configuration start-up sequencer
// assumes inclusion by bare name from rtl/
`ifndef CSS_DEFINES_SVH
`define CSS_DEFINES_SVH

// sequence clock choices
`define CSS_CLKSEL_CONFIG 2'h0
`define CSS_CLKSEL_USER 2'h1
`define CSS_CLKSEL_JTAG 2'h2

// lock wait stage choices
`define CSS_LOCKSTAGE_NONE 2'h0
`define CSS_LOCKSTAGE_DONE 2'h1
`define CSS_LOCKSTAGE_TRI 2'h2
`define CSS_LOCKSTAGE_WRITE 2'h3

// width of the flop initialisation pulse, in sequence steps
`define CSS_INIT_STEPS 4'h1

`endif

/* rtl/css_pkg.sv */
// types for the configuration start-up sequencer
// assumes css_defines.svh is compiled alongside
package css_pkg;

    typedef enum logic [5:0] {
        CSS_IDLE = 6'b00_0001,
        CSS_INIT = 6'b00_0010,
        CSS_DONE = 6'b00_0100,
        CSS_TRI = 6'b00_1000,
        CSS_WRITE = 6'b01_0000,
        CSS_USER = 6'b10_0000
    } css_state_type;

    typedef struct packed {
        logic [1:0] clk_select;
        logic wait_chain_done;
        logic [1:0] lock_stage;
    } css_options_type;

    typedef struct packed {
        logic init_request;
        logic tristate_request;
        logic user_clock_tick;
    } css_user_type;

    typedef struct packed {
        logic global_flop_init;
        logic global_output_tristate;
        logic global_write_gate;
    } css_globals_type;

endpackage : css_pkg

/* rtl/css_sequencer.sv */
// configuration start-up sequencer: from end of configuration to user mode
// assumes every input synchronous to clk; sequence clocks arrive as ticks
`timescale 1ns/1ns
`default_nettype none
`include "css_defines.svh"

// Functional notes
// - at the end of configuration a flop initialisation pulse is issued.
// - by default the output tristate releases one sequence step after done rises.
// - by default the write gate releases one sequence step after the tristate release.
// - dual-purpose configuration pins become user pins when done rises.
// - after done rises, dual-purpose pins drive nothing until the output tristate is released; before that they follow dual_pin_config_drive.
// - optionally tristate and write-gate release wait for every chained done pin.
// - optionally the sequence pauses at a chosen stage until selected clock managers lock.
// - by default the sequence steps on the configuration clock.
// - optionally the sequence steps on a user clock from the user sequencer primitive.
// - the user may assert output tristate, and in CSS_USER also flop initialisation, via that primitive.
// - under JTAG configuration the sequence may step on the test clock.
module css_sequencer (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic config_finished,
    input wire css_pkg::css_options_type options,
    input wire logic config_clock_tick,
    input wire logic jtag_clock_tick,
    input wire css_pkg::css_user_type user_sequencer_primitive,
    input wire logic [3:0] clock_manager_locked,
    input wire logic [3:0] clock_manager_select,
    input wire logic chain_done_in,
    input wire logic [7:0] dual_pin_out,
    input wire logic [7:0] dual_pin_config_out,
    input wire logic dual_pin_config_drive,
    output logic done_out,
    output logic done_oe_n,
    output logic dual_pins_user,
    output logic [7:0] dual_pin_o,
    output logic [7:0] dual_pin_oe_n,
    output css_pkg::css_globals_type globals,
    output logic storage_update_allowed
);
    import css_pkg::*;

    // ****************************************
    // sequence clock selection
    // ****************************************
    // every sequence clock arrives as a one-cycle tick in the clk domain
    function automatic logic pick_tick(input logic [1:0] sel, input logic cfg, input logic usr, input logic jtg);
        case (sel)
            `CSS_CLKSEL_USER: pick_tick = usr;
            `CSS_CLKSEL_JTAG: pick_tick = jtg;
            default: pick_tick = cfg;
        endcase
    endfunction : pick_tick

    logic step;
    assign step = pick_tick(options.clk_select, config_clock_tick,
        user_sequencer_primitive.user_clock_tick, jtag_clock_tick);

    // ****************************************
    // stalls
    // ****************************************
    function automatic logic lock_ok(input logic [1:0] stage, input logic [1:0] here,
        input logic [3:0] lk, input logic [3:0] sel);
        lock_ok = (stage != here) || ((lk & sel) == sel);
    endfunction : lock_ok

    // wired chain level includes our own done pin
    logic chain_ok;
    assign chain_ok = !options.wait_chain_done || chain_done_in;

    css_state_type state;
    css_state_type next_state;
    logic [3:0] init_count;

    // one stage per selected tick (IDLE leaves on config_finished alone), no way back except reset
    always_comb begin
        next_state = state;
        case (state)
            CSS_IDLE: begin
                if (config_finished) begin
                    next_state = CSS_INIT;
                end
            end
            CSS_INIT: begin
                if (step && init_count == 4'h0) begin
                    next_state = CSS_DONE;
                end
            end
            CSS_DONE: begin
                if (step && chain_ok
                    && lock_ok(options.lock_stage, `CSS_LOCKSTAGE_DONE, clock_manager_locked,
                               clock_manager_select)) begin
                    next_state = CSS_TRI;
                end
            end
            CSS_TRI: begin
                if (step && chain_ok
                    && lock_ok(options.lock_stage, `CSS_LOCKSTAGE_TRI, clock_manager_locked,
                               clock_manager_select)) begin
                    next_state = CSS_WRITE;
                end
            end
            CSS_WRITE: begin
                if (step && lock_ok(options.lock_stage, `CSS_LOCKSTAGE_WRITE, clock_manager_locked,
                                    clock_manager_select)) begin
                    next_state = CSS_USER;
                end
            end
            CSS_USER: next_state = CSS_USER;
            default: next_state = CSS_IDLE;
        endcase
    end

    // ****************************************
    // state
    // ****************************************
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state <= CSS_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // init pulse length counter
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            init_count <= 4'h0;
        end else if (state == CSS_IDLE && config_finished) begin
            init_count <= `CSS_INIT_STEPS - 4'h1;
        end else if (state == CSS_INIT && step && init_count != 4'h0) begin
            init_count <= init_count - 4'h1;
        end
    end

    // ****************************************
    // global signals
    // ****************************************
    function automatic logic tri_released(input css_state_type s);
        tri_released = (s == CSS_TRI) || (s == CSS_WRITE) || (s == CSS_USER);
    endfunction : tri_released

    function automatic logic write_released(input css_state_type s);
        write_released = (s == CSS_WRITE) || (s == CSS_USER);
    endfunction : write_released

    function automatic logic done_released(input css_state_type s);
        done_released = !((s == CSS_IDLE) || (s == CSS_INIT));
    endfunction : done_released

    logic flop_init;
    logic output_tristate;
    logic write_gate;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            flop_init <= 1'b1;
        end else begin
            flop_init <= (next_state == CSS_INIT)
                || (next_state == CSS_USER && user_sequencer_primitive.init_request);
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            output_tristate <= 1'b1;
        end else begin
            output_tristate <= !tri_released(next_state)
                || user_sequencer_primitive.tristate_request;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            write_gate <= 1'b1;
        end else begin
            write_gate <= !write_released(next_state);
        end
    end

    // one packed bundle out, each bit from its own flop
    assign globals = '{global_flop_init: flop_init, global_output_tristate: output_tristate,
        global_write_gate: write_gate};
    assign storage_update_allowed = !write_gate;

    // ****************************************
    // done pin and dual-purpose pins
    // ****************************************
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            done_out <= 1'b0;
        end else begin
            done_out <= done_released(next_state);
        end
    end

    // done pin is dedicated, never floated
    assign done_oe_n = 1'b0;
    assign dual_pins_user = done_out;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            dual_pin_o <= 8'h00;
        end else if (dual_pins_user) begin
            dual_pin_o <= dual_pin_out;
        end else begin
            dual_pin_o <= dual_pin_config_out;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            dual_pin_oe_n <= 8'hFF;
        end else if (!done_out) begin
            dual_pin_oe_n <= {8{!dual_pin_config_drive}};
        end else begin
            dual_pin_oe_n <= {8{globals.global_output_tristate}};
        end
    end

endmodule : css_sequencer
`default_nettype wire

/* verification/css_sequencer_chk.sv */
// port checker for the start-up sequencer
// assumes bind onto css_sequencer, one clock domain
`timescale 1ns/1ns
`default_nettype none
module css_sequencer_chk (
    input wire logic clk,
    input wire logic rst_n,
    input wire css_pkg::css_options_type options,
    input wire logic chain_done_in,
    input wire logic [3:0] clock_manager_locked,
    input wire logic [3:0] clock_manager_select,
    input wire logic done_out,
    input wire logic dual_pins_user,
    input wire logic [7:0] dual_pin_out,
    input wire logic [7:0] dual_pin_o,
    input wire logic [7:0] dual_pin_oe_n,
    input wire css_pkg::css_globals_type globals,
    input wire logic storage_update_allowed
);
    import css_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence s_tri_was_low;
        !$past(globals.global_output_tristate);
    endsequence
    a_init_pulse: assert property ($rose(done_out) |-> $past(globals.global_flop_init) && !globals.global_flop_init)
        else $error("init pulse");
    a_tri_order: assert property (!done_out |-> globals.global_output_tristate && globals.global_write_gate)
        else $error("early release");
    a_tri_after_done: assert property ($fell(globals.global_output_tristate) |-> $past(done_out))
        else $error("tristate before done");
    a_pin_data: assert property (dual_pins_user |=> dual_pin_o == $past(dual_pin_out))
        else $error("user pin data");
    a_write_order: assert property ($fell(globals.global_write_gate) |-> s_tri_was_low)
        else $error("write before tristate");
    a_pins_user: assert property (dual_pins_user == done_out)
        else $error("pin handover");
    a_pin_float: assert property (done_out && globals.global_output_tristate |=> dual_pin_oe_n == 8'hFF)
        else $error("pin drives");
    a_chain_hold: assert property (options.wait_chain_done && !chain_done_in
        |=> !($fell(globals.global_output_tristate) && globals.global_write_gate) && !$fell(globals.global_write_gate))
        else $error("chain ignored");
    a_lock_hold: assert property (options.lock_stage == 2'h1 && globals.global_write_gate
        && (clock_manager_locked & clock_manager_select) != clock_manager_select
        |=> !$fell(globals.global_output_tristate) && !$fell(globals.global_write_gate))
        else $error("lock ignored");
    a_store_block: assert property (storage_update_allowed == !globals.global_write_gate)
        else $error("storage gate");
endmodule : css_sequencer_chk
bind css_sequencer css_sequencer_chk u_chk (
    .clk(clk),
    .rst_n(rst_n),
    .options(options),
    .chain_done_in(chain_done_in),
    .clock_manager_locked(clock_manager_locked),
    .clock_manager_select(clock_manager_select),
    .done_out(done_out),
    .dual_pins_user(dual_pins_user),
    .dual_pin_out(dual_pin_out),
    .dual_pin_o(dual_pin_o),
    .dual_pin_oe_n(dual_pin_oe_n),
    .globals(globals),
    .storage_update_allowed(storage_update_allowed)
);
`default_nettype wire

/* verification/css_far_side.sv */
// far side: chained done pins and clock managers
// assumes the bench commands a late peer and lock flags
`timescale 1ns/1ns
`default_nettype none
module css_far_side (
    input wire logic done_out,
    input wire logic peer_late,
    input wire logic [3:0] lock_set,
    output logic chain_done_in,
    output logic [3:0] clock_manager_locked
);
    // wired done line, low while any device unfinished
    assign chain_done_in = done_out & ~peer_late;
    assign clock_manager_locked = lock_set;
endmodule : css_far_side
`default_nettype wire

/* verification/tb_css_sequencer.sv */
// self-checking bench for the start-up sequencer
// assumes css_pkg, checker and css_far_side compiled first
`timescale 1ns/1ns
`default_nettype none
module tb_css_sequencer;
    import css_pkg::*;
    logic clk = 0, rst_n = 0, fin = 0, late = 0, done, doe_n, user, chain, upd;
    logic [2:0] tk = 0;
    logic [1:0] ureq = 0;
    logic [3:0] lock = 0, sel = 0, locked;
    logic [7:0] uout = 8'hA5, pin_o, pin_oe_n;
    css_options_type opt = '0;
    css_globals_type g;
    int fails = 0, num_checks = 0;
    always #5 clk = ~clk;
    css_far_side far (.done_out(done), .peer_late(late), .lock_set(lock), .chain_done_in(chain),
        .clock_manager_locked(locked));
    css_sequencer uut (.clk(clk), .rst_n(rst_n), .config_finished(fin), .options(opt),
        .config_clock_tick(tk[0]), .jtag_clock_tick(tk[2]), .user_sequencer_primitive({ureq, tk[1]}),
        .clock_manager_locked(locked), .clock_manager_select(sel), .chain_done_in(chain),
        .dual_pin_out(uout), .dual_pin_config_out(8'h3C), .dual_pin_config_drive(1'b1),
        .done_out(done), .done_oe_n(doe_n), .dual_pins_user(user), .dual_pin_o(pin_o),
        .dual_pin_oe_n(pin_oe_n), .globals(g), .storage_update_allowed(upd));
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            $display("Error %s expected %h seen %h", name, exp, got);
            fails++;
        end
    endtask : chk
    task automatic step(input int src);
        @(posedge clk) tk <= 3'h1 << src;
        @(posedge clk) tk <= 3'h0;
        #1;
    endtask : step
    task automatic start(input css_options_type o);
        @(posedge clk) rst_n <= 0;
        opt <= o;
        fin <= 0;
        @(posedge clk) rst_n <= 1;
        @(posedge clk) fin <= 1;
        @(posedge clk) #1;
    endtask : start
    task automatic t_default;
        start('0);
        chk("globals", 8'h07, 8'(g));
        chk("pin out", 8'h3C, pin_o);
        chk("update", 8'h00, 8'(upd));
        step(0);
        chk("globals", 8'h03, 8'(g));
        chk("done", 8'h01, 8'(user));
        chk("done oe", 8'h00, 8'(doe_n));
        step(0);
        chk("globals", 8'h01, 8'(g));
        @(posedge clk) #1;
        chk("pin oe", 8'h00, pin_oe_n);
        chk("pin out", 8'hA5, pin_o);
        step(0);
        chk("globals", 8'h00, 8'(g));
        chk("update", 8'h01, 8'(upd));
        step(0);
        @(posedge clk) ureq <= 2'h3;
        repeat (3) @(posedge clk);
        #1 chk("globals", 8'h06, 8'(g));
        chk("pin oe", 8'hFF, pin_oe_n);
        @(posedge clk) ureq <= 2'h0;
        repeat (3) @(posedge clk);
        #1 chk("globals", 8'h00, 8'(g));
    endtask : t_default
    task automatic t_chain;
        @(posedge clk) late <= 1;
        start(5'h04);
        repeat (3) step(0);
        chk("globals", 8'h03, 8'(g));
        @(posedge clk) late <= 0;
        repeat (2) step(0);
        chk("globals", 8'h00, 8'(g));
    endtask : t_chain
    task automatic t_lock;
        for (int s = 1; s < 4; s++) begin
            @(posedge clk) sel <= 4'h3;
            lock <= 4'h1;
            ureq <= 2'h2;
            start({3'h0, s[1:0]});
            repeat (5) step(0);
            chk("globals", 8'h03 >> (s - 1), 8'(g));
            @(posedge clk) lock <= 4'h3;
            repeat (4) step(0);
            chk("globals", 8'h04, 8'(g));
            @(posedge clk) ureq <= 2'h0;
        end
    endtask : t_lock
    task automatic t_clock;
        for (int s = 1; s < 3; s++) begin
            start({s[1:0], 3'h0});
            step(0);
            chk("done", 8'h00, 8'(done));
            step(s);
            chk("done", 8'h01, 8'(done));
        end
    endtask : t_clock
    task automatic stop_test;
        if (fails == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : stop_test
    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        stop_test();
    end
    initial begin
        t_default();
        t_chain();
        t_lock();
        t_clock();
        stop_test();
    end
endmodule : tb_css_sequencer
`default_nettype wire
